/* dit_consts.vh */
`ifndef DIT_CONSTS_VH
`define DIT_CONSTS_VH

// ----------------------------------------
// control register map
// ----------------------------------------
`define DIT_CTRL_ADDR 32'hf1000260
`define DIT_PRESENT_BIT 31
`define DIT_RELEASE_BIT 26
`define DIT_HOLD_BIT 25
`define DIT_CAP_LSB 8
`define DIT_CAP_MSB 15
`define DIT_CNT_LSB 0
`define DIT_CNT_MSB 7

// ----------------------------------------
// reset values
// ----------------------------------------
`define DIT_HOLD_RST 1'b0
`define DIT_RELEASE_RST 1'b0
`define DIT_COUNT_RST 8'h00
`define DIT_RDATA_RST 32'h00000000

// ----------------------------------------
// store geometry
// ----------------------------------------
`define DIT_CAPACITY 8'h69
`define DIT_LAST_SLOT 7'h68
`define DIT_SLOT_BITS 7
`define DIT_WORD_BITS 4
`define DIT_LAST_WORD 4'hf
`define DIT_STORE_WORDS 1680
`define DIT_FIFO_DEPTH 4
`define DIT_FIFO_AW 2

// ----------------------------------------
// timing
// ----------------------------------------
`define DIT_MCLK_NS 20
`define DIT_ISO_CYCLE_NS 125000
`define DIT_ISO_CYCLE_CYC (`DIT_ISO_CYCLE_NS / `DIT_MCLK_NS)

// ----------------------------------------
// fetch states
// ----------------------------------------
`define DIT_ST_IDLE 1'b0
`define DIT_ST_READ 1'b1

`endif

/* dit_fifo.v */
`timescale 1ns/1ps
`default_nettype none
`include "dit_consts.vh"

module dit_fifo #(
	parameter W = 33,
	parameter D = `DIT_FIFO_DEPTH,
	parameter AW = `DIT_FIFO_AW
) (
	input wire mclk,
	input wire rst_n,
	input wire flush,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wr_ptr_ff;
	reg [AW-1:0] rd_ptr_ff;
	reg [AW:0] level_ff;
	wire push;
	wire pop;

	assign in_ready = (level_ff != D[AW:0]);
	assign out_valid = (level_ff != {(AW+1){1'b0}});
	assign out_data = mem[rd_ptr_ff];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always @(posedge mclk) begin
		if (push) begin
			mem[wr_ptr_ff] <= in_data;
		end
	end

	// pointers wrap naturally; depth is a power of two
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			level_ff <= {(AW+1){1'b0}};
		end else if (flush) begin
			wr_ptr_ff <= {AW{1'b0}};
			rd_ptr_ff <= {AW{1'b0}};
			level_ff <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_ff <= wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= rd_ptr_ff + 1'b1;
			end
			if (push && !pop) begin
				level_ff <= level_ff + 1'b1;
			end else if (pop && !push) begin
				level_ff <= level_ff - 1'b1;
			end
		end
	end
endmodule

`default_nettype wire

/* dit_transport.v */
`timescale 1ns/1ps
`default_nettype none
`include "dit_consts.vh"

module dit_transport #(
	parameter ISO_GAP_CYC = `DIT_ISO_CYCLE_CYC
) (
	input wire mclk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	output wire [31:0] reg_rdata,
	output wire reg_ack,
	input wire scalable_format_sel,
	input wire burst_capture_flag,
	input wire [15:0] packet_byte_setting,
	input wire sen_valid,
	input wire [31:0] sen_data,
	input wire sen_last,
	output wire sen_ready,
	output wire iso_valid,
	output wire [31:0] iso_data,
	output wire iso_last,
	input wire iso_ready
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [`DIT_SLOT_BITS-1:0] next_slot;
		input [`DIT_SLOT_BITS-1:0] s;
		begin
			if (s == `DIT_LAST_SLOT) begin
				next_slot = {`DIT_SLOT_BITS{1'b0}};
			end else begin
				next_slot = s + 1'b1;
			end
		end
	endfunction

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg hold_frames_flag_ff;
	reg release_frames_flag_ff;
	reg [7:0] count_ff;
	reg [7:0] avail_ff;
	reg [7:0] fetch_left_ff;
	reg [7:0] send_left_ff;
	reg [`DIT_SLOT_BITS-1:0] wr_slot_ff;
	reg [`DIT_SLOT_BITS-1:0] rd_slot_ff;
	reg [`DIT_WORD_BITS-1:0] wr_word_ff;
	reg [`DIT_WORD_BITS-1:0] rd_word_ff;
	reg wr_ovf_ff;
	reg fetch_st_ff;
	reg [31:0] rdata_ff;
	reg ack_ff;
	reg [31:0] frame_store_queue [0:`DIT_STORE_WORDS-1];
	reg [`DIT_WORD_BITS-1:0] len_mem [0:`DIT_STORE_WORDS/16-1];

	wire ctrl_hit;
	wire ctrl_wr;
	wire burst_on;
	wire cap_fire;
	wire frame_done;
	wire store_full;
	wire overwrite;
	wire send_ok;
	wire fetch_start;
	wire fetch_push;
	wire fetch_last;
	wire fetch_end;
	wire flush;
	wire link_fire;
	wire link_done;
	wire [1:0] pace_ok;
	wire [1:0] pace_fire;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [32:0] fifo_out_data;
	wire [`DIT_SLOT_BITS+`DIT_WORD_BITS-1:0] wr_addr;
	wire [`DIT_SLOT_BITS+`DIT_WORD_BITS-1:0] rd_addr;
	wire [7:0] req_n;
	wire [13:0] pkt_words;

	// ----------------------------------------
	// register access
	// ----------------------------------------
	assign ctrl_hit = (reg_addr == `DIT_CTRL_ADDR);
	assign ctrl_wr = reg_wr & ctrl_hit;
	// zero count asks for everything held right now
	assign req_n = (reg_wdata[`DIT_CNT_MSB:`DIT_CNT_LSB] == 8'h00) ?
		count_ff : reg_wdata[`DIT_CNT_MSB:`DIT_CNT_LSB];
	// falling hold throws the store away
	assign flush = ctrl_wr & hold_frames_flag_ff &
		~reg_wdata[`DIT_HOLD_BIT];

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_ff <= `DIT_RDATA_RST;
			ack_ff <= 1'b0;
		end else begin
			ack_ff <= reg_rd | reg_wr;
			if (reg_rd) begin
				rdata_ff <= `DIT_RDATA_RST;
				if (ctrl_hit) begin
					rdata_ff[`DIT_PRESENT_BIT] <= 1'b1;
					rdata_ff[`DIT_RELEASE_BIT] <= release_frames_flag_ff;
					rdata_ff[`DIT_HOLD_BIT] <= hold_frames_flag_ff;
					rdata_ff[`DIT_CAP_MSB:`DIT_CAP_LSB] <= `DIT_CAPACITY;
					rdata_ff[`DIT_CNT_MSB:`DIT_CNT_LSB] <= count_ff;
				end
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign reg_ack = ack_ff;

	// ----------------------------------------
	// hold and release control
	// ----------------------------------------
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_frames_flag_ff <= `DIT_HOLD_RST;
			release_frames_flag_ff <= `DIT_RELEASE_RST;
			fetch_left_ff <= `DIT_COUNT_RST;
			send_left_ff <= `DIT_COUNT_RST;
		end else if (ctrl_wr) begin
			hold_frames_flag_ff <= reg_wdata[`DIT_HOLD_BIT];
			release_frames_flag_ff <= 1'b0;
			fetch_left_ff <= `DIT_COUNT_RST;
			send_left_ff <= `DIT_COUNT_RST;
			// release only means something with hold also set
			if (reg_wdata[`DIT_HOLD_BIT] && reg_wdata[`DIT_RELEASE_BIT] &&
				req_n != 8'h00) begin
				release_frames_flag_ff <= 1'b1;
				fetch_left_ff <= req_n;
				send_left_ff <= req_n;
			end
		end else begin
			if (fetch_start && hold_frames_flag_ff) begin
				fetch_left_ff <= fetch_left_ff - 1'b1;
			end
			if (link_done && release_frames_flag_ff) begin
				send_left_ff <= send_left_ff - 1'b1;
				if (send_left_ff == 8'h01) begin
					release_frames_flag_ff <= 1'b0;
				end
			end
		end
	end

	// ----------------------------------------
	// capture pacing and burst
	// ----------------------------------------
	assign burst_on = burst_capture_flag & scalable_format_sel;
	// burst lets the sensor run free; the store soaks up the excess
	assign sen_ready = burst_on | pace_ok[0];
	assign cap_fire = sen_valid & sen_ready;
	assign frame_done = cap_fire & sen_last;
	assign store_full = (count_ff == `DIT_CAPACITY);
	assign overwrite = frame_done & store_full;
	assign wr_addr = {wr_slot_ff, wr_word_ff};

	// ----------------------------------------
	// packet pacers: 0 capture, 1 link
	// ----------------------------------------
	assign pkt_words = (packet_byte_setting[15:2] == 14'h0000) ?
		14'h0001 : packet_byte_setting[15:2];
	assign pace_fire[0] = cap_fire & ~burst_on;
	assign pace_fire[1] = link_fire;

	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : pacer
			reg [13:0] wcnt_ff;
			reg [15:0] gap_ff;
			assign pace_ok[g] = (gap_ff == 16'h0000);
			// one packet per bus cycle: smaller packets, slower frames
			always @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					wcnt_ff <= 14'h0000;
					gap_ff <= 16'h0000;
				end else if (gap_ff != 16'h0000) begin
					gap_ff <= gap_ff - 1'b1;
				end else if (pace_fire[g]) begin
					if (wcnt_ff + 14'h0001 >= pkt_words) begin
						wcnt_ff <= 14'h0000;
						gap_ff <= ISO_GAP_CYC[15:0];
					end else begin
						wcnt_ff <= wcnt_ff + 14'h0001;
					end
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// store write side
	// ----------------------------------------
	// words past the slot size are dropped, not wrapped
	always @(posedge mclk) begin
		if (cap_fire && !wr_ovf_ff) begin
			frame_store_queue[wr_addr] <= sen_data;
		end
		if (frame_done) begin
			len_mem[wr_slot_ff] <= wr_word_ff;
		end
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_slot_ff <= {`DIT_SLOT_BITS{1'b0}};
			wr_word_ff <= {`DIT_WORD_BITS{1'b0}};
			wr_ovf_ff <= 1'b0;
		end else if (frame_done) begin
			wr_slot_ff <= next_slot(wr_slot_ff);
			wr_word_ff <= {`DIT_WORD_BITS{1'b0}};
			wr_ovf_ff <= 1'b0;
		end else if (cap_fire) begin
			if (wr_word_ff == `DIT_LAST_WORD) begin
				wr_ovf_ff <= 1'b1;
			end else begin
				wr_word_ff <= wr_word_ff + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// store read side
	// ----------------------------------------
	assign send_ok = ~hold_frames_flag_ff |
		(release_frames_flag_ff & (fetch_left_ff != 8'h00));
	assign fetch_start = (fetch_st_ff == `DIT_ST_IDLE) &
		(avail_ff != 8'h00) & send_ok & ~flush;
	assign rd_addr = {rd_slot_ff, rd_word_ff};
	assign fetch_push = (fetch_st_ff == `DIT_ST_READ) & fifo_in_ready;
	assign fetch_last = (rd_word_ff == len_mem[rd_slot_ff]);
	assign fetch_end = fetch_push & fetch_last;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			fetch_st_ff <= `DIT_ST_IDLE;
			rd_slot_ff <= {`DIT_SLOT_BITS{1'b0}};
			rd_word_ff <= {`DIT_WORD_BITS{1'b0}};
		end else if (flush) begin
			fetch_st_ff <= `DIT_ST_IDLE;
			rd_slot_ff <= frame_done ? next_slot(wr_slot_ff) : wr_slot_ff;
			rd_word_ff <= {`DIT_WORD_BITS{1'b0}};
		end else begin
			case (fetch_st_ff)
				`DIT_ST_IDLE: begin
					// a full store ages out its oldest unread frame
					if (overwrite) begin
						rd_slot_ff <= next_slot(rd_slot_ff);
					end
					if (fetch_start) begin
						fetch_st_ff <= `DIT_ST_READ;
						rd_word_ff <= {`DIT_WORD_BITS{1'b0}};
					end
				end
				`DIT_ST_READ: begin
					// oldest slot is on the way out; an overwrite now corrupts it
					if (fetch_end) begin
						fetch_st_ff <= `DIT_ST_IDLE;
						rd_slot_ff <= next_slot(rd_slot_ff);
					end else if (fetch_push) begin
						rd_word_ff <= rd_word_ff + 1'b1;
					end
				end
				default: begin
					fetch_st_ff <= `DIT_ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------
	// frame counts
	// ----------------------------------------
	assign link_fire = iso_valid & iso_ready;
	assign link_done = link_fire & iso_last;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= `DIT_COUNT_RST;
			avail_ff <= `DIT_COUNT_RST;
		end else if (flush) begin
			count_ff <= `DIT_COUNT_RST;
			avail_ff <= `DIT_COUNT_RST;
		end else begin
			// full store: newest replaces oldest, totals stay put
			if (frame_done && !store_full && !link_done) begin
				count_ff <= count_ff + 1'b1;
			end else if (link_done && !(frame_done && !store_full)) begin
				count_ff <= count_ff - 1'b1;
			end
			if (frame_done && !overwrite && !fetch_start) begin
				avail_ff <= avail_ff + 1'b1;
			end else if (fetch_start && !(frame_done && !overwrite)) begin
				avail_ff <= avail_ff - 1'b1;
			end
		end
	end

	// ----------------------------------------
	// link side buffer
	// ----------------------------------------
	dit_fifo #(
		.W(33),
		.D(`DIT_FIFO_DEPTH),
		.AW(`DIT_FIFO_AW)
	) u_fifo (
		.mclk(mclk),
		.rst_n(rst_n),
		.flush(flush),
		.in_valid(fetch_st_ff == `DIT_ST_READ),
		.in_ready(fifo_in_ready),
		.in_data({fetch_last, frame_store_queue[rd_addr]}),
		.out_valid(fifo_out_valid),
		.out_ready(iso_ready & pace_ok[1]),
		.out_data(fifo_out_data)
	);

	// link pacer holds words back between packets
	assign iso_valid = fifo_out_valid & pace_ok[1];
	assign iso_data = fifo_out_data[31:0];
	assign iso_last = fifo_out_data[32];
endmodule

`default_nettype wire

/* dit_transport_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dit_consts.vh"

module dit_transport_checker #(
	parameter ISO_GAP_CYC = 4
) (
	input wire mclk,
	input wire rst_n,
	input wire reg_wr,
	input wire reg_rd,
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire [31:0] reg_rdata,
	input wire reg_ack,
	input wire scalable_format_sel,
	input wire burst_capture_flag,
	input wire [15:0] packet_byte_setting,
	input wire sen_valid,
	input wire [31:0] sen_data,
	input wire sen_last,
	input wire sen_ready,
	input wire iso_valid,
	input wire [31:0] iso_data,
	input wire iso_last,
	input wire iso_ready
);
	// ----------------------------------------
	// shadow of the host-written flags
	// ----------------------------------------
	reg hold_ff;
	reg rel_ff;
	wire ctl_wr = reg_wr && reg_addr == `DIT_CTRL_ADDR;
	wire ctl_hit = reg_addr == `DIT_CTRL_ADDR;
	wire one_word = packet_byte_setting[15:3] == 13'h0;
	wire burst = scalable_format_sel && burst_capture_flag;

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_ff <= 1'b0;
			rel_ff <= 1'b0;
		end else if (ctl_wr) begin
			hold_ff <= reg_wdata[`DIT_HOLD_BIT];
			rel_ff <= reg_wdata[`DIT_RELEASE_BIT];
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_ack_follows: assert property ((reg_rd || reg_wr) |=> reg_ack)
		else $error("access not acknowledged");
	a_ack_single: assert property (!(reg_rd || reg_wr) |=> !reg_ack)
		else $error("acknowledge without access");
	// release reads back only while a written release may still be pending
	a_ctrl_fields: assert property (reg_rd && ctl_hit |=>
		reg_rdata[31:27] == 5'h10 && reg_rdata[25] == hold_ff &&
		(!reg_rdata[26] || rel_ff) && reg_rdata[24:16] == 9'h0 &&
		reg_rdata[15:8] == `DIT_CAPACITY)
		else $error("control read fields wrong");
	a_unmapped_zero: assert property (reg_rd && !ctl_hit |=>
		reg_rdata == 32'h00000000)
		else $error("unmapped read not zero");
	a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data moved without read");
	a_hold_stops: assert property (hold_ff && !rel_ff |-> !iso_valid)
		else $error("frame sent while held");
	a_iso_stands: assert property (iso_valid && !iso_ready &&
		!reg_wr |=> iso_valid && $stable(iso_data) && $stable(iso_last))
		else $error("link word changed before taken");
	a_burst_open: assert property (burst |-> sen_ready)
		else $error("burst capture throttled");
	a_sen_paced: assert property (sen_valid && sen_ready &&
		!burst && one_word ##1 !burst |-> !sen_ready)
		else $error("capture not paced by packet size");
	a_iso_paced: assert property (iso_valid && iso_ready &&
		one_word |=> !iso_valid)
		else $error("readout not paced by packet size");

	c_release: cover property (rel_ff && iso_valid && iso_ready && iso_last);
	c_burst: cover property (burst && sen_valid && sen_last);
	c_paced: cover property (!burst && sen_valid && !sen_ready);
endmodule

bind dit_transport dit_transport_checker #(.ISO_GAP_CYC(ISO_GAP_CYC)) chk (
	.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
	.reg_ack(reg_ack), .scalable_format_sel(scalable_format_sel),
	.burst_capture_flag(burst_capture_flag),
	.packet_byte_setting(packet_byte_setting), .sen_valid(sen_valid),
	.sen_data(sen_data), .sen_last(sen_last), .sen_ready(sen_ready),
	.iso_valid(iso_valid), .iso_data(iso_data), .iso_last(iso_last),
	.iso_ready(iso_ready)
);
`default_nettype wire

/* dit_host_link.sv */
`timescale 1ns/1ps
`default_nettype none

module dit_host_link (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic stall,
	input wire logic iso_valid,
	input wire logic [31:0] iso_data,
	input wire logic iso_last,
	output logic iso_ready
);
	// ----------------------------------------
	// link layer sink, stalls on request
	// ----------------------------------------
	logic [32:0] rx_q[$];

	initial iso_ready = 1'b0;

	always @(posedge mclk) begin
		if (rst_n && iso_valid === 1'b1 && iso_ready)
			rx_q.push_back({iso_last, iso_data});
		#1 iso_ready = rst_n && !stall;
	end
endmodule
`default_nettype wire

/* dit_transport_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dit_consts.vh"

module dit_transport_bench;
	localparam [31:0] CA = `DIT_CTRL_ADDR;
	logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, sen_valid = 0;
	logic sen_last = 0, scalable_format_sel = 1, burst_capture_flag = 1;
	logic [31:0] reg_addr = 0, reg_wdata = 0, sen_data = 0;
	logic [15:0] packet_byte_setting = 0;
	logic [31:0] seed = 32'h6a09;
	wire [31:0] reg_rdata, iso_data;
	wire reg_ack, sen_ready, iso_valid, iso_last, iso_ready;
	wire stall = seed[3] & seed[5];
	logic [32:0] exp_q[$];
	int error_cnt = 0;
	int tests_run = 0;

	dit_transport #(.ISO_GAP_CYC(4)) uut (.mclk(mclk), .rst_n(rst_n),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
		.scalable_format_sel(scalable_format_sel),
		.burst_capture_flag(burst_capture_flag),
		.packet_byte_setting(packet_byte_setting), .sen_valid(sen_valid),
		.sen_data(sen_data), .sen_last(sen_last), .sen_ready(sen_ready),
		.iso_valid(iso_valid), .iso_data(iso_data), .iso_last(iso_last),
		.iso_ready(iso_ready));
	dit_host_link host (.mclk(mclk), .rst_n(rst_n), .stall(stall),
		.iso_valid(iso_valid), .iso_data(iso_data), .iso_last(iso_last),
		.iso_ready(iso_ready));

	always #10 mclk = ~mclk;
	// seed moves on the falling edge so drivers see it settled
	always @(negedge mclk) seed = lfsr(seed);

	// ----------------------------------------
	// expectations and reporting
	// ----------------------------------------
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	function automatic [31:0] ctl(input h, input r, input [7:0] n);
		ctl = {1'b1, 4'h0, r, h, 9'h000, `DIT_CAPACITY, n};
	endfunction

	task automatic check(input [32:0] got, input [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic hang;
		error_cnt++;
		$display("unexpected at %0t: wait ran out, got %h expected %h",
			$time, 1'b0, 1'b1);
		test_done;
	endtask

	// ----------------------------------------
	// drivers
	// ----------------------------------------
	task automatic acc(input w, input [31:0] a, d, output [31:0] q);
		int k;
		reg_wr = w;
		reg_rd = !w;
		reg_addr = a;
		reg_wdata = d;
		@(posedge mclk);
		#1 reg_wr = 0;
		reg_rd = 0;
		for (k = 0; k < 4 && reg_ack !== 1'b1; k++) @(posedge mclk) #1;
		if (reg_ack !== 1'b1) hang;
		q = reg_rdata;
		// one idle cycle so the next call does not re-raise the strobe
		@(posedge mclk) #1;
	endtask

	task automatic rd(input [31:0] a, input [31:0] e);
		logic [31:0] q;
		acc(1'b0, a, 32'h0, q);
		check(q, e);
	endtask

	task automatic wr(input [31:0] a, input [31:0] d);
		logic [31:0] q;
		acc(1'b1, a, d, q);
	endtask

	task automatic frame(input int n);
		int i, k;
		for (i = 0; i < n; i++) begin
			sen_valid = 1;
			sen_data = seed;
			sen_last = i == n - 1;
			for (k = 0; k < 50 && sen_ready !== 1'b1; k++) @(posedge mclk) #1;
			if (sen_ready !== 1'b1) hang;
			exp_q.push_back({sen_last, sen_data});
			@(posedge mclk) #1;
		end
		sen_valid = 0;
		sen_last = 0;
		@(posedge mclk) #1;
	endtask

	// extra words would show up during the settle cycles
	task automatic rx(input int n);
		int k;
		for (k = 0; k < 3000 && host.rx_q.size() < n; k++) @(posedge mclk) #1;
		if (k == 3000) hang;
		repeat (20) @(posedge mclk);
		#1 check(host.rx_q.size(), n);
		while (host.rx_q.size() > 0)
			check(host.rx_q.pop_front(), exp_q.pop_front());
	endtask

	initial begin
		int i;
		repeat (2) @(posedge mclk);
		#1 rst_n = 1;
		rd(CA, ctl(0, 0, 0));
		rd(32'hf0f00614, 32'h0);
		wr(32'hf0f00614, 32'h0);
		wr(CA, ctl(1, 0, 0));
		packet_byte_setting = 16'h0004;
		frame(2);
		frame(3);
		frame(1);
		rx(0);
		rd(CA, ctl(1, 0, 3));
		wr(CA, ctl(1, 1, 1));
		rx(2);
		rd(CA, ctl(1, 0, 2));
		packet_byte_setting = seed[15:0] & 16'h001c;
		wr(CA, ctl(1, 1, 0));
		rx(4);
		rd(CA, ctl(1, 0, 0));
		scalable_format_sel = 0;
		packet_byte_setting = 16'h0000;
		frame(3);
		frame(2);
		wr(CA, ctl(0, 0, 0));
		exp_q.delete();
		rx(0);
		rd(CA, ctl(0, 0, 0));
		scalable_format_sel = 1;
		burst_capture_flag = 0;
		wr(CA, ctl(1, 0, 0));
		for (i = 0; i <= `DIT_CAPACITY; i++) frame(1);
		void'(exp_q.pop_front());
		rd(CA, ctl(1, 0, `DIT_CAPACITY));
		wr(CA, ctl(1, 1, 3));
		// release still pending, first frame not yet on the link
		rd(CA, ctl(1, 1, `DIT_CAPACITY));
		rx(3);
		rd(CA, ctl(1, 0, `DIT_CAPACITY - 8'h03));
		wr(CA, ctl(0, 0, 0));
		// hold off: frames stream straight through the store
		exp_q.delete();
		frame(2);
		rx(2);
		rd(CA, ctl(0, 0, 0));
		test_done;
	end
endmodule
`default_nettype wire
